// ===== hdl/cioi_pkg.sv
// Constants and helpers for the processor I/O and interrupt engine
package cioi_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_MADR = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_PSU = 8'h10;
  localparam logic [7:0] OFS_RDAT = 8'h14;
  localparam logic [7:0] OFS_PC = 8'h18;
  // Command codes written to the command register
  localparam logic [3:0] CMD_RD_CTRL = 4'h0;
  localparam logic [3:0] CMD_RD_DATA = 4'h1;
  localparam logic [3:0] CMD_WR_CTRL = 4'h2;
  localparam logic [3:0] CMD_WR_DATA = 4'h3;
  localparam logic [3:0] CMD_EXT_RD = 4'h4;
  localparam logic [3:0] CMD_EXT_WR = 4'h5;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_LOAD_PSU = 4'h8;
  localparam logic [3:0] CMD_PRESET_PSU = 4'h9;
  localparam logic [3:0] CMD_CLEAR_PSU = 4'ha;
  localparam logic [3:0] CMD_RETURN = 4'hb;
  localparam logic [3:0] CMD_RETURN_EN = 4'hc;
  // Upper status byte fields, write mask, and status byte and program address reset values
  localparam int PSU_SENSE = 7;
  localparam int PSU_FLAG = 6;
  localparam int PSU_II = 5;
  localparam logic [7:0] PSU_WMASK = 8'h7f;
  localparam logic [7:0] PSU_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_IND = 1;
  localparam int STAT_IR_LSB = 8;
  // Address pin roles during I/O cycles, vector indirect bit and return stack pointer width
  localparam int ADR_EXT = 13;
  localparam int ADR_DC = 14;
  localparam int VEC_IND = 7;
  localparam int SP_W = 3;
  // Jammed call opcode; value is arbitrary
  localparam logic [7:0] ZCALL_OP = 8'h5a;

  function automatic logic cmd_ok(input logic [3:0] c);
    return c <= CMD_RETURN_EN;
  endfunction

  function automatic logic cmd_bus(input logic [3:0] c);
    return c <= CMD_MEM_WR;
  endfunction

  function automatic logic cmd_mem(input logic [3:0] c);
    return (c == CMD_MEM_RD) || (c == CMD_MEM_WR);
  endfunction

  function automatic logic cmd_ext(input logic [3:0] c);
    return (c == CMD_EXT_RD) || (c == CMD_EXT_WR);
  endfunction

  function automatic logic cmd_wr(input logic [3:0] c);
    return (c == CMD_WR_CTRL) || (c == CMD_WR_DATA)
        || (c == CMD_EXT_WR) || (c == CMD_MEM_WR);
  endfunction

  function automatic logic [12:0] cmd_len(input logic [3:0] c);
    if (c <= CMD_WR_DATA || c >= CMD_RETURN) begin
      return 13'h0001;
    end
    if (cmd_mem(c)) begin
      return 13'h0003;
    end
    return 13'h0002;
  endfunction
endpackage

// ===== hdl/cioi_if.sv
// Carriers between the engine core, its bus engine and its return stack
`timescale 1ns/1ps
interface cioi_bus_if;
  logic start;
  logic mem_sel;
  logic wr;
  logic interrupt_acknowledge;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctl (output start, mem_sel, wr, interrupt_acknowledge, addr, wdata, input done, rdata);
  modport eng (input start, mem_sel, wr, interrupt_acknowledge, addr, wdata, output done, rdata);
endinterface

interface cioi_stack_if;
  logic push;
  logic pop;
  logic [12:0] din;
  logic [12:0] dout;
  modport ctl (output push, pop, din, input dout);
  modport ram (input push, pop, din, output dout);
endinterface

// ===== hdl/cioi_bus_eng.sv
// External operation handshake engine driving the processor bus pins
`timescale 1ns/1ps
module cioi_bus_eng (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core side
  cioi_bus_if.eng bus,
  // Bus pins
  output logic operation_request_q,
  output logic interrupt_acknowledge_q,
  output logic mio_q,
  output logic rw_q,
  output logic [14:0] adr_q,
  output logic [7:0] dout_q,
  output logic oe_q,
  input wire logic op_ack,
  input wire logic [7:0] din
);
  typedef enum logic [1:0] {BE_IDLE, BE_REQ, BE_DRAIN} cioi_be_t;
  cioi_be_t st_q, st_d;
  logic operation_request_d, interrupt_acknowledge_d, mio_d, rw_d, oe_d, done_q, done_d;
  logic [14:0] adr_d;
  logic [7:0] dout_d, rdat_q, rdat_d;

  assign bus.done = done_q;
  assign bus.rdata = rdat_q;

  always_comb begin
    st_d = st_q;
    operation_request_d = operation_request_q;
    interrupt_acknowledge_d = interrupt_acknowledge_q;
    mio_d = mio_q;
    rw_d = rw_q;
    adr_d = adr_q;
    dout_d = dout_q;
    oe_d = oe_q;
    rdat_d = rdat_q;
    done_d = 1'b0;
    unique case (st_q)
      BE_IDLE: if (bus.start) begin
        st_d = BE_REQ;
        operation_request_d = 1'b1;
        interrupt_acknowledge_d = bus.interrupt_acknowledge; // [R21]
        mio_d = bus.mem_sel;
        rw_d = bus.wr;
        adr_d = bus.addr;
        dout_d = bus.wdata;
        oe_d = bus.wr; // [R06]
      end
      BE_REQ: if (op_ack) begin
        // Request held until the far end answers
        st_d = BE_DRAIN; // [R18]
        rdat_d = din; // [R06]
        operation_request_d = 1'b0;
        interrupt_acknowledge_d = 1'b0; // [R21]
        oe_d = 1'b0;
      end
      BE_DRAIN: if (!op_ack) begin
        // Stale acknowledge must not end the next cycle early
        st_d = BE_IDLE;
        done_d = 1'b1;
      end
      default: st_d = BE_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= BE_IDLE;
      operation_request_q <= 1'b0;
      interrupt_acknowledge_q <= 1'b0;
      mio_q <= 1'b0;
      rw_q <= 1'b0;
      adr_q <= 15'h0000;
      dout_q <= 8'h00;
      oe_q <= 1'b0;
      rdat_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      operation_request_q <= operation_request_d;
      interrupt_acknowledge_q <= interrupt_acknowledge_d;
      mio_q <= mio_d;
      rw_q <= rw_d;
      adr_q <= adr_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
    end
  end
endmodule

// ===== hdl/cioi_ras.sv
// Eight-level return address stack
`timescale 1ns/1ps
module cioi_ras (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stack port
  cioi_stack_if.ram stk
);
  logic [12:0] mem [2**cioi_pkg::SP_W];
  logic [cioi_pkg::SP_W-1:0] sp_q, sp_d;

  // Pointer wraps silently; nesting past eight overwrites the oldest
  always_comb begin
    sp_d = sp_q;
    if (stk.push) begin
      sp_d = sp_q + 3'h1;
    end else if (stk.pop) begin
      sp_d = sp_q - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_q <= 3'h0;
    end else begin
      sp_q <= sp_d;
    end
    if (stk.push) begin
      mem[sp_d] <= stk.din;
    end
  end

  assign stk.dout = mem[sp_q];
endmodule

// ===== hdl/cioi_top.sv
// Processor I/O and vectored interrupt engine with APB command port
//
// How it works
// R01: Sense bit of the status byte tracks the sense pin every clock.
// R02: Flag pin equals the flag bit, changed in the instruction's last cycle.
// R03: Each single-byte I/O command moves one byte; data/control select marks pair.
// R04: Single-byte I/O: request high, memory select low, extended low, select per pair.
// R05: Extended I/O puts the device byte on address 7:0 and extended high.
// R06: Extended read stores the bus byte; extended write drives the operand byte.
// R07: Memory-mapped devices answer memory cycles like memory.
// R08: One interrupt input; an eight-bit vector picks among 128 targets.
// R09: Accepting an interrupt sets the inhibit bit.
// R10: While inhibit is set the interrupt input is ignored.
// R11: Inhibit set by load or preset; cleared by reset, clear, load, return-enable.
// R12: The running instruction completes before the interrupt sequence.
// R13: Call opcode is jammed; second byte fetched with acknowledge high.
// R14: Jammed call pushes next address and branches relative to address zero.
// R15: Negative offsets wrap modulo 8192.
// R16: Vector bit 7 set means an indirect address fetch first.
// R17: Returns pop the stack; only return-and-enable clears inhibit.
// R18: Request held until acknowledge arrives, then dropped.
// R19: Request seen before the last cycle jams the call in that cycle.
// R20: Polled systems may force one fixed vector on acknowledge.
// R21: Acknowledge rises with request and falls after operation acknowledge.
// R22: Low seven vector bits are a two's complement offset.
// R23: Interrupt request is sampled on the clock and held until acknowledged.
`timescale 1ns/1ps
module cioi_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Processor bus
  output logic OPERATION_REQUEST,
  input wire logic OPERATION_ACKNOWLEDGE,
  output logic MEM_IO_SELECT,
  output logic READ_WRITE,
  output logic [14:0] ADDRESS,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  // Interrupt
  input wire logic INTERRUPT_REQUEST,
  output logic INTERRUPT_ACKNOWLEDGE,
  // Single-bit I/O
  input wire logic SENSE,
  output logic FLAG
);
  typedef enum logic [3:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_LAST, S_VEC_ISSUE, S_VEC_WAIT, S_CALL,
    S_IND_ISSUE, S_IND_WAIT
  } cioi_state_t;

  cioi_bus_if bus_c();
  cioi_stack_if stk_c();

  cioi_state_t st_q, st_d;
  logic [12:0] pc_q, pc_d, ind_q, ind_d;
  logic [7:0] psu_q, psu_d, rdat_q, rdat_d, vec_q, vec_d, hi_q, hi_d, ir_q, ir_d;
  logic [3:0] cmd_q, cmd_d;
  logic [15:0] opnd_q, opnd_d;
  logic [14:0] madr_q, madr_d;
  logic pend_q, pend_d, second_q, second_d, interrupt_request_q;
  logic pready_d, pslverr_d, busy, apb_wr;
  logic [31:0] prdata_d;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == cioi_pkg::OFS_CMD || a == cioi_pkg::OFS_OPND
        || a == cioi_pkg::OFS_MADR || a == cioi_pkg::OFS_STAT
        || a == cioi_pkg::OFS_PSU || a == cioi_pkg::OFS_RDAT
        || a == cioi_pkg::OFS_PC;
  endfunction

  assign busy = pend_q || (st_q != S_IDLE);
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE && is_mapped(PADDR);
  assign FLAG = psu_q[cioi_pkg::PSU_FLAG]; // [R02]

  cioi_bus_eng u_bus (
    .clk(MCLK),
    .rst_n(RST_N),
    .bus(bus_c.eng),
    .operation_request_q(OPERATION_REQUEST),
    .interrupt_acknowledge_q(INTERRUPT_ACKNOWLEDGE),
    .mio_q(MEM_IO_SELECT),
    .rw_q(READ_WRITE),
    .adr_q(ADDRESS),
    .dout_q(DATA_OUT),
    .oe_q(DATA_OE),
    .op_ack(OPERATION_ACKNOWLEDGE),
    .din(DATA_IN)
  );

  cioi_ras u_ras (
    .clk(MCLK),
    .rst_n(RST_N),
    .stk(stk_c.ram)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus request fields

  always_comb begin
    bus_c.start = (st_q == S_ISSUE) || (st_q == S_VEC_ISSUE) || (st_q == S_IND_ISSUE);
    bus_c.interrupt_acknowledge = (st_q == S_VEC_ISSUE); // [R13]
    bus_c.wr = (st_q == S_ISSUE) && cioi_pkg::cmd_wr(cmd_q); // [R04]
    bus_c.wdata = opnd_q[7:0]; // [R06]
    bus_c.mem_sel = 1'b0;
    bus_c.addr = 15'h0000;
    if (st_q == S_IND_ISSUE) begin
      bus_c.mem_sel = 1'b1;
      bus_c.addr = {2'b00, ind_q};
    end else if (st_q == S_ISSUE) begin
      if (cioi_pkg::cmd_mem(cmd_q)) begin
        bus_c.mem_sel = 1'b1; // [R07]
        bus_c.addr = madr_q;
      end else if (cioi_pkg::cmd_ext(cmd_q)) begin
        bus_c.addr[7:0] = opnd_q[15:8]; // [R05]
        bus_c.addr[cioi_pkg::ADR_EXT] = 1'b1; // [R05]
      end else begin
        // Bit 0 of the single-byte codes picks data over control
        bus_c.addr[cioi_pkg::ADR_DC] = (cmd_q == cioi_pkg::CMD_RD_DATA)
            || (cmd_q == cioi_pkg::CMD_WR_DATA); // [R03] [R04]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and registers

  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    psu_d = psu_q;
    cmd_d = cmd_q;
    pend_d = pend_q;
    opnd_d = opnd_q;
    madr_d = madr_q;
    rdat_d = rdat_q;
    vec_d = vec_q;
    ind_d = ind_q;
    hi_d = hi_q;
    ir_d = ir_q;
    second_d = second_q;
    stk_c.push = 1'b0;
    stk_c.pop = 1'b0;
    stk_c.din = pc_q;
    if (apb_wr) begin
      if (PADDR == cioi_pkg::OFS_CMD && !busy) begin
        cmd_d = PWDATA[3:0];
        pend_d = cioi_pkg::cmd_ok(PWDATA[3:0]);
      end
      if (PADDR == cioi_pkg::OFS_OPND) begin
        opnd_d = PWDATA[15:0];
      end
      if (PADDR == cioi_pkg::OFS_MADR) begin
        madr_d = PWDATA[14:0];
      end
    end
    unique case (st_q)
      S_IDLE: begin
        if (interrupt_request_q && !psu_q[cioi_pkg::PSU_II]) begin // [R10] [R23]
          psu_d[cioi_pkg::PSU_II] = 1'b1; // [R09]
          ir_d = cioi_pkg::ZCALL_OP; // [R13]
          st_d = S_VEC_ISSUE;
        end else if (pend_q) begin
          pend_d = 1'b0;
          st_d = cioi_pkg::cmd_bus(cmd_q) ? S_ISSUE : S_LAST;
        end
      end
      S_ISSUE: st_d = S_WAIT;
      S_WAIT: if (bus_c.done) begin
        if (!cioi_pkg::cmd_wr(cmd_q)) begin
          rdat_d = bus_c.rdata; // [R06]
        end
        st_d = S_LAST;
      end
      S_LAST: begin
        // Instruction completes here before any interrupt is taken
        pc_d = pc_q + cioi_pkg::cmd_len(cmd_q); // [R12]
        unique case (cmd_q)
          cioi_pkg::CMD_LOAD_PSU: psu_d = opnd_q[7:0] & cioi_pkg::PSU_WMASK; // [R11]
          cioi_pkg::CMD_PRESET_PSU: psu_d = psu_q | (opnd_q[7:0] & cioi_pkg::PSU_WMASK); // [R11]
          cioi_pkg::CMD_CLEAR_PSU: psu_d = psu_q & ~(opnd_q[7:0] & cioi_pkg::PSU_WMASK); // [R11]
          cioi_pkg::CMD_RETURN, cioi_pkg::CMD_RETURN_EN: begin
            stk_c.pop = 1'b1; // [R17]
            pc_d = stk_c.dout; // [R17]
            if (cmd_q == cioi_pkg::CMD_RETURN_EN) begin
              psu_d[cioi_pkg::PSU_II] = 1'b0; // [R17] [R11]
            end
          end
          default: ;
        endcase
        st_d = S_IDLE;
        // A request seen before this cycle replaces the next fetch
        if (interrupt_request_q && !psu_d[cioi_pkg::PSU_II]) begin // [R19] [R10]
          psu_d[cioi_pkg::PSU_II] = 1'b1; // [R09]
          ir_d = cioi_pkg::ZCALL_OP; // [R13]
          st_d = S_VEC_ISSUE;
        end
      end
      S_VEC_ISSUE: st_d = S_VEC_WAIT;
      S_VEC_WAIT: if (bus_c.done) begin
        vec_d = bus_c.rdata; // [R08] [R13]
        st_d = S_CALL;
      end
      S_CALL: begin
        stk_c.push = 1'b1; // [R14]
        // Sign extension to 13 bits wraps negatives modulo 8192
        ind_d = {{6{vec_q[6]}}, vec_q[6:0]}; // [R22] [R15] [R14]
        second_d = 1'b0;
        if (vec_q[cioi_pkg::VEC_IND]) begin // [R16]
          st_d = S_IND_ISSUE;
        end else begin
          pc_d = {{6{vec_q[6]}}, vec_q[6:0]}; // [R14]
          st_d = S_IDLE;
        end
      end
      S_IND_ISSUE: st_d = S_IND_WAIT;
      S_IND_WAIT: if (bus_c.done) begin
        if (!second_q) begin
          hi_d = bus_c.rdata;
          ind_d = ind_q + 13'h0001;
          second_d = 1'b1;
          st_d = S_IND_ISSUE;
        end else begin
          pc_d = {hi_q[4:0], bus_c.rdata}; // [R16]
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    psu_d[cioi_pkg::PSU_SENSE] = SENSE; // [R01]
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer

  always_comb begin
    pready_d = PSEL && PENABLE && !PREADY;
    pslverr_d = pready_d && !is_mapped(PADDR);
    prdata_d = 32'h00000000;
    if (pready_d && !PWRITE) begin
      unique case (PADDR)
        cioi_pkg::OFS_CMD: prdata_d[3:0] = cmd_q;
        cioi_pkg::OFS_OPND: prdata_d[15:0] = opnd_q;
        cioi_pkg::OFS_MADR: prdata_d[14:0] = madr_q;
        cioi_pkg::OFS_STAT: begin
          prdata_d[cioi_pkg::STAT_BUSY] = busy;
          prdata_d[cioi_pkg::STAT_IND] = vec_q[cioi_pkg::VEC_IND];
          prdata_d[cioi_pkg::STAT_IR_LSB +: 8] = ir_q;
        end
        cioi_pkg::OFS_PSU: prdata_d[7:0] = psu_q; // [R01]
        cioi_pkg::OFS_RDAT: prdata_d[7:0] = rdat_q;
        cioi_pkg::OFS_PC: prdata_d[12:0] = pc_q;
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_q <= S_IDLE;
      pc_q <= cioi_pkg::PC_RST;
      psu_q <= cioi_pkg::PSU_RST; // [R11]
      cmd_q <= 4'h0;
      pend_q <= 1'b0;
      opnd_q <= 16'h0000;
      madr_q <= 15'h0000;
      rdat_q <= 8'h00;
      vec_q <= 8'h00;
      ind_q <= 13'h0000;
      hi_q <= 8'h00;
      ir_q <= 8'h00;
      second_q <= 1'b0;
      interrupt_request_q <= 1'b0;
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      psu_q <= psu_d;
      cmd_q <= cmd_d;
      pend_q <= pend_d;
      opnd_q <= opnd_d;
      madr_q <= madr_d;
      rdat_q <= rdat_d;
      vec_q <= vec_d;
      ind_q <= ind_d;
      hi_q <= hi_d;
      ir_q <= ir_d;
      second_q <= second_d;
      interrupt_request_q <= INTERRUPT_REQUEST; // [R23]
      PRDATA <= prdata_d;
      PREADY <= pready_d;
      PSLVERR <= pslverr_d;
    end
  end
endmodule

// ===== sim/cioi_top_asserts.sv
// Checker for the processor bus, interrupt and flag pins of the engine
`timescale 1ns/1ps
module cioi_top_chk (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Processor bus
  input wire logic OPERATION_REQUEST,
  input wire logic OPERATION_ACKNOWLEDGE,
  input wire logic MEM_IO_SELECT,
  input wire logic READ_WRITE,
  input wire logic [14:0] ADDRESS,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE,
  // Interrupt and flag
  input wire logic INTERRUPT_REQUEST,
  input wire logic INTERRUPT_ACKNOWLEDGE,
  input wire logic FLAG
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence req_taken;
    OPERATION_REQUEST && OPERATION_ACKNOWLEDGE;
  endsequence
  sequence req_gone;
    !OPERATION_REQUEST && !INTERRUPT_ACKNOWLEDGE && !DATA_OE;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  req_bound_a: assert property ($rose(OPERATION_REQUEST) |-> ##[0:40] req_taken)
    else $error("request never acknowledged");
  req_hold_a: assert property (OPERATION_REQUEST && !OPERATION_ACKNOWLEDGE |=> OPERATION_REQUEST)
    else $error("request dropped before acknowledge");
  ack_drop_a: assert property (req_taken |=> req_gone)
    else $error("request not released after acknowledge");
  fields_hold_a: assert property (OPERATION_REQUEST && $past(OPERATION_REQUEST) |->
    $stable({MEM_IO_SELECT, READ_WRITE, ADDRESS, DATA_OUT, INTERRUPT_ACKNOWLEDGE}))
    else $error("bus fields moved during request");
  drive_write_a: assert property (DATA_OE == (OPERATION_REQUEST && READ_WRITE))
    else $error("data enable not tied to write request");
  vector_read_a: assert property (INTERRUPT_ACKNOWLEDGE |->
    OPERATION_REQUEST && !MEM_IO_SELECT && !READ_WRITE)
    else $error("vector fetch is not an I/O read");
  vector_rise_a: assert property ($rose(INTERRUPT_ACKNOWLEDGE) |-> $rose(OPERATION_REQUEST))
    else $error("acknowledge did not rise with request");
  vector_cause_a: assert property ($rose(INTERRUPT_ACKNOWLEDGE) |-> $past(INTERRUPT_REQUEST))
    else $error("acknowledge without interrupt request");
  flag_quiet_a: assert property ($changed(FLAG) |-> !OPERATION_REQUEST)
    else $error("flag moved during a bus cycle");
endmodule

bind cioi_top cioi_top_chk u_chk (.MCLK(MCLK), .RST_N(RST_N),
  .OPERATION_REQUEST(OPERATION_REQUEST), .OPERATION_ACKNOWLEDGE(OPERATION_ACKNOWLEDGE),
  .MEM_IO_SELECT(MEM_IO_SELECT), .READ_WRITE(READ_WRITE), .ADDRESS(ADDRESS),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .INTERRUPT_REQUEST(INTERRUPT_REQUEST),
  .INTERRUPT_ACKNOWLEDGE(INTERRUPT_ACKNOWLEDGE), .FLAG(FLAG));

// ===== sim/cioi_dev_model.sv
// Memory, I/O device and interrupting peripheral on the processor bus
`timescale 1ns/1ps
module cioi_dev_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench controls
  input wire logic slow,
  input wire logic irq_go,
  input wire logic [7:0] vec,
  // Processor bus
  input wire logic req,
  input wire logic mio,
  input wire logic rw,
  input wire logic [14:0] adr,
  input wire logic [7:0] dout,
  input wire logic interrupt_acknowledge,
  output logic ack,
  output logic [7:0] din,
  output logic irq
);
  logic [7:0] mem [256];
  logic [7:0] dev_q;
  logic [1:0] wait_q;
  logic lmio;
  logic lrw;
  logic [14:0] ladr;
  logic [7:0] ldout;
  always @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'(i * 29 + 7);
      din <= 8'h00;
      ack <= 1'b0;
      irq <= 1'b0;
      wait_q <= 2'h0;
      dev_q <= 8'h00;
    end else begin
      if (irq_go) irq <= 1'b1;
      else if (interrupt_acknowledge) irq <= 1'b0;
      if (ack) begin
        if (!req) ack <= 1'b0;
      end else if (req && wait_q < (slow ? 2'h3 : 2'h0)) begin
        wait_q <= wait_q + 2'h1;
        din <= ~din;
      end else if (req) begin
        ack <= 1'b1;
        wait_q <= 2'h0;
        lmio <= mio;
        lrw <= rw;
        ladr <= adr;
        ldout <= dout;
        // Vector byte forced on acknowledge alone, as a polled system would
        if (interrupt_acknowledge) din <= vec;
        else if (!rw) din <= mio ? mem[adr[7:0]] : dev_q;
        if (rw && mio) mem[adr[7:0]] <= dout;
        if (rw && !mio) dev_q <= dout;
      end else begin
        // Released bus toggles each cycle between the last byte and its complement
        din <= ~din;
      end
    end
  end
endmodule

// ===== sim/test_cioi_top.sv
// Self-checking bench for the processor I/O and interrupt engine
`timescale 1ns/1ps
module test_cioi_top;
  logic MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic OPERATION_REQUEST, OPERATION_ACKNOWLEDGE, MEM_IO_SELECT, READ_WRITE, DATA_OE;
  logic [14:0] ADDRESS;
  logic [7:0] DATA_IN, DATA_OUT, vec, wd, m5;
  logic INTERRUPT_REQUEST, INTERRUPT_ACKNOWLEDGE, SENSE, FLAG, slow, irq_go, er;
  logic [12:0] pc;
  logic [3:0] c;
  logic [3:0] seq [8] = '{4'h3, 4'h1, 4'h2, 4'h0, 4'h5, 4'h4, 4'h7, 4'h6};
  int miscompares, comparisons, acks, n0;
  cioi_top dut (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OPERATION_REQUEST(OPERATION_REQUEST),
    .OPERATION_ACKNOWLEDGE(OPERATION_ACKNOWLEDGE), .MEM_IO_SELECT(MEM_IO_SELECT),
    .READ_WRITE(READ_WRITE), .ADDRESS(ADDRESS), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .INTERRUPT_REQUEST(INTERRUPT_REQUEST),
    .INTERRUPT_ACKNOWLEDGE(INTERRUPT_ACKNOWLEDGE), .SENSE(SENSE), .FLAG(FLAG));
  cioi_dev_model u_dev (.clk(MCLK), .rst_n(RST_N), .slow(slow), .irq_go(irq_go),
    .vec(vec), .req(OPERATION_REQUEST), .mio(MEM_IO_SELECT), .rw(READ_WRITE),
    .adr(ADDRESS), .dout(DATA_OUT), .interrupt_acknowledge(INTERRUPT_ACKNOWLEDGE),
    .ack(OPERATION_ACKNOWLEDGE), .din(DATA_IN), .irq(INTERRUPT_REQUEST));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] memv(input int i);
    return 8'(i * 29 + 7);
  endfunction
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, cioi_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rd[cioi_pkg::STAT_BUSY] !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
  endtask
  task automatic cmd(input logic [3:0] k, input logic [15:0] op);
    apb(1'b1, cioi_pkg::OFS_OPND, {16'h0, op});
    apb(1'b1, cioi_pkg::OFS_CMD, {28'h0, k});
    idle();
  endtask
  // Missing acknowledge is judged by the caller, so no error here
  task automatic ackwait();
    int n;
    n = 0;
    while (INTERRUPT_ACKNOWLEDGE !== 1'b1 && n < 40) begin
      @(posedge MCLK);
      n++;
    end
    idle();
  endtask
  task automatic intr(input logic [7:0] v);
    vec <= v;
    irq_go <= 1'b1;
    @(posedge MCLK);
    irq_go <= 1'b0;
    ackwait();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge INTERRUPT_ACKNOWLEDGE) acks++;
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    miscompares++;
    test_done();
  end
  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, SENSE, slow, irq_go} = 7'h0;
    {PADDR, PWDATA, vec, wd} = 56'h0;
    miscompares = 0;
    comparisons = 0;
    acks = 0;
    pc = 13'h0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    rdchk(cioi_pkg::OFS_PSU, 32'h0, "status byte");
    rdchk(cioi_pkg::OFS_PC, 32'h0, "program address");
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, cioi_pkg::OFS_MADR, 32'h1523);
    // Writes come before reads so each read returns the byte just stored
    for (int i = 0; i < 8; i++) begin
      c = seq[i];
      slow <= i[0];
      if (!i[0]) wd = 8'h5a ^ 8'(i * 17);
      cmd(c, {8'hc6, wd});
      pc = pc + ((c < 4'h4) ? 13'h1 : (c < 4'h6) ? 13'h2 : 13'h3);
      rdchk(cioi_pkg::OFS_PC, 32'(pc), "program address");
      check("space select", 32'(u_dev.lmio), 32'(c > 4'h5));
      check("direction", 32'(u_dev.lrw), 32'(!i[0]));
      if (c < 4'h4) check("io select", 32'(u_dev.ladr[14:13]), {30'h0, c[0], 1'b0});
      else if (c < 4'h6) check("ext select", 32'({u_dev.ladr[13], u_dev.ladr[7:0]}),
          32'h1c6);
      else check("mem address", 32'(u_dev.ladr), 32'h1523);
      if (!i[0]) check("write byte", 32'(u_dev.ldout), 32'(wd));
      else rdchk(cioi_pkg::OFS_RDAT, 32'(wd), "read byte");
    end
    cmd(4'h9, 16'h0040);
    check("flag pin", 32'(FLAG), 32'h1);
    SENSE <= 1'b1;
    cmd(4'h8, 16'h009f);
    check("flag pin", 32'(FLAG), 32'h0);
    rdchk(cioi_pkg::OFS_PSU, 32'h9f, "status byte");
    SENSE <= 1'b0;
    rdchk(cioi_pkg::OFS_PSU, 32'h1f, "status byte");
    cmd(4'h8, 16'h0020);
    pc = pc + 13'h6;
    n0 = acks;
    intr(8'h7e);
    check("ignored request", acks, n0);
    check("request held", 32'(INTERRUPT_REQUEST), 32'h1);
    cmd(4'ha, 16'h0020);
    pc = pc + 13'h2;
    ackwait();
    check("vector fetches", acks, n0 + 1);
    rdchk(cioi_pkg::OFS_PC, 32'h1ffe, "vector target");
    rdchk(cioi_pkg::OFS_PSU, 32'h20, "status byte");
    rdchk(cioi_pkg::OFS_STAT, {16'h0, cioi_pkg::ZCALL_OP, 8'h0}, "jammed call");
    cmd(4'hc, 16'h0);
    rdchk(cioi_pkg::OFS_PC, 32'(pc), "return address");
    rdchk(cioi_pkg::OFS_PSU, 32'h0, "status byte");
    intr(8'h85);
    m5 = memv(5);
    rdchk(cioi_pkg::OFS_PC, {19'h0, m5[4:0], memv(6)}, "indirect target");
    rdchk(cioi_pkg::OFS_STAT, {16'h0, cioi_pkg::ZCALL_OP, 8'h2}, "indirect mark");
    cmd(4'hb, 16'h0);
    rdchk(cioi_pkg::OFS_PC, 32'(pc), "return address");
    rdchk(cioi_pkg::OFS_PSU, 32'h20, "status byte");
    test_done();
  end
endmodule
